// ---- tb/uorc_checker.sv ----
`timescale 1ns/100ps
module uorc_checker
    import uorc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic OPTION_LOAD,
    input wire logic [31:0] OPTION_WORD,
    input wire logic SUPPLY_BELOW_TRIP,
    input wire logic CORE_RESET_N,
    input wire logic SYSTEM_RESET_REQ,
    input wire logic LOWVOLT_DETECT_ON,
    input wire logic [3:0] LOWVOLT_LEVEL_CODE,
    input wire logic LOW_SUPPLY_TRIP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_detect; OPTION_LOAD |=> LOWVOLT_DETECT_ON == !$past(OPTION_WORD[12]); endproperty
    a_detect: assert property (p_detect) else $error("detector enable wrong");
    property p_level; OPTION_LOAD |=> LOWVOLT_LEVEL_CODE == 4'hF - $past(OPTION_WORD[11:8]); endproperty
    a_level: assert property (p_level) else $error("level code wrong");
    property p_det_off; !LOWVOLT_DETECT_ON |=> !LOW_SUPPLY_TRIP; endproperty
    a_det_off: assert property (p_det_off) else $error("trip while detector off");
    property p_trip_cause; LOW_SUPPLY_TRIP |-> $past(SUPPLY_BELOW_TRIP); endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip without low supply");
    property p_req_cause; SYSTEM_RESET_REQ |-> $past(LOW_SUPPLY_TRIP); endproperty
    a_req_cause: assert property (p_req_cause) else $error("reset request without trip");
    property p_core_hold; CORE_RESET_N |=> CORE_RESET_N; endproperty
    a_core_hold: assert property (p_core_hold) else $error("core reset reasserted");
    property p_b_drop; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response repeated");
    property p_r_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    c_core: cover property ($rose(CORE_RESET_N));
    c_trip: cover property ($rose(LOW_SUPPLY_TRIP));
    c_req: cover property ($rose(SYSTEM_RESET_REQ));
endmodule

bind uorc_top uorc_checker i_uorc_checker (.*);

// ---- tb/uorc_top_tb.sv ----
`timescale 1ns/100ps
module uorc_top_tb;
    import uorc_pkg::*;
    logic clk = 0, rstn = 0, tick = 0, load = 0, raw = 0;
    logic [31:0] word = 0, wdata = 0, rdata;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [3:0] wstrb = 0, lvl;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic core_n, sysreq, det, trip, ren, awready, wready, bvalid, arready, rvalid;
    logic [30:0] base;
    logic [1:0] bresp, rresp;
    int miscompares = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    uorc_top i_uorc_top (.REF_CLK(clk), .RESETN(rstn), .SLOW_OSC_TICK(tick),
        .OPTION_LOAD(load), .OPTION_WORD(word), .SUPPLY_BELOW_TRIP(raw), .CORE_RESET_N(core_n),
        .SYSTEM_RESET_REQ(sysreq), .LOWVOLT_DETECT_ON(det), .LOWVOLT_LEVEL_CODE(lvl),
        .LOW_SUPPLY_TRIP(trip), .VECTOR_REMAP_ENABLE(ren), .VECTOR_TABLE_BASE(base),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task conclude;
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tmo(input int n);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask
    function logic [31:0] mrg(input logic [31:0] o, n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task tk;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask
    task rw(input logic v);
        @(posedge clk);
        raw <= v;
    endtask
    task ld(input logic [31:0] w);
        @(posedge clk);
        word <= w;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask
    task rst;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n);
        chk(32'(bresp), 32'(r));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(n);
        chk(rdata, d);
        chk(32'(rresp), 32'(r));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] w, v;
        int s;
        void'($urandom(32'hE5411E9D));
        for (int k = 0; k < 2; k++) begin
            s = k ? ($urandom % 8) + 1 : 0;
            rst();
            cyc(1);
            chk(32'(core_n), 0);
            rd(8'h20, 32'hFFFFFFFF, 2'h0);
            rd(8'h24, 32'h00000000, 2'h0);
            wr(8'h24, 32'hFFFFFFFF, 4'hF, 2'h0);
            ld({8'hFF, 8'hFF - 8'(s), 16'hFFFF});
            repeat (s) begin
                cyc(2);
                chk(32'(core_n), 0);
                tk();
            end
            cyc(3);
            chk(32'(core_n), 1);
        end
        for (int k = 0; k < 8; k++) begin
            w = k == 0 ? 32'h00000000 : $urandom;
            ld(w);
            cyc(1);
            chk(32'(det), 32'(!w[12]));
            chk(32'(lvl), 32'(4'hF - w[11:8]));
            wr(8'h20, ~w, 4'hF, 2'h2);
            rd(8'h20, w, 2'h0);
        end
        chk(32'(core_n), 1);
        rd(8'h30, 32'h00000000, 2'h2);
        w = $urandom | 32'h80000000;
        v = $urandom & 32'h7FFFFFFF;
        wr(8'h24, w, 4'hF, 2'h0);
        cyc(1);
        chk({ren, base}, w);
        wr(8'h24, v, 4'h9, 2'h0);
        w = mrg(w, v, 4'h9);
        rd(8'h24, w, 2'h0);
        chk({ren, base}, w);
        ld(32'hFFFFAFFF);
        rw(1'b1);
        cyc(1);
        chk(32'(trip), 1);
        cyc(1);
        chk(32'(sysreq), 1);
        rd(8'h28, 32'h0000000F, 2'h0);
        wr(8'h28, 32'h00000000, 4'hF, 2'h2);
        rw(1'b0);
        s = ($urandom % 4) + 2;
        ld({16'hFFFF, 8'hCF, 8'hFF - 8'(s)});
        repeat (2) begin
            rw(1'b1);
            repeat (s - 1) tk();
            cyc(2);
            chk(32'(trip), 0);
            rw(1'b0);
        end
        rw(1'b1);
        repeat (s) tk();
        cyc(3);
        chk(32'(trip), 1);
        chk(32'(sysreq), 0);
        rw(1'b0);
        ld(32'hFFFFBFFF);
        rw(1'b1);
        cyc(3);
        chk(32'(trip), 0);
        chk(32'(det), 0);
        conclude();
    end
    initial begin
        #1250000;
        miscompares++;
        conclude();
    end
endmodule

// ---- verilog/uorc_map.svh ----
`ifndef UORC_MAP_SVH
`define UORC_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UORC_OFS_USER 8'h20
`define UORC_OFS_REMAP 8'h24
`define UORC_OFS_STATUS 8'h28

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UORC_USER_RST 32'hFFFFFFFF
`define UORC_REMAP_RST 32'h00000000
`define UORC_ZERO32 32'h00000000

// ----------------------------------------
// Field positions and constants
// ----------------------------------------
`define UORC_FULL8 8'hFF
`define UORC_FULL4 4'hF
`define UORC_ONE8 8'h01
`define UORC_REMAP_EN_BIT 31
`define UORC_RESP_OKAY 2'h0
`define UORC_RESP_SLVERR 2'h2

`endif

// ---- verilog/uorc_pkg.sv ----
package uorc_pkg;

    typedef struct packed {
        logic [7:0] reserved_hi;
        logic [7:0] por_delay;
        logic reserved_15;
        logic lowvolt_reset_disable;
        logic lowvolt_filter_disable;
        logic lowvolt_detect_disable;
        logic [3:0] lowvolt_level_select;
        logic [7:0] lowvolt_filter_count;
    } uorc_user_type;

    typedef struct packed {
        logic vector_remap_enable;
        logic [30:0] vector_table_base;
    } uorc_remap_type;

    typedef enum logic [1:0] {
        UORC_POR_WAIT = 2'b00,
        UORC_POR_DELAY = 2'b01,
        UORC_POR_RUN = 2'b10
    } uorc_por_state_type;

endpackage

// ---- verilog/uorc_top.sv ----
`timescale 1ns/100ps
`include "uorc_map.svh"

module uorc_top
    import uorc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic SLOW_OSC_TICK,
    input wire logic OPTION_LOAD,
    input wire logic [31:0] OPTION_WORD,
    input wire logic SUPPLY_BELOW_TRIP,
    output logic CORE_RESET_N,
    output logic SYSTEM_RESET_REQ,
    output logic LOWVOLT_DETECT_ON,
    output logic [3:0] LOWVOLT_LEVEL_CODE,
    output logic LOW_SUPPLY_TRIP,
    output logic VECTOR_REMAP_ENABLE,
    output logic [30:0] VECTOR_TABLE_BASE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] span_from_field(input logic [7:0] field);
        span_from_field = `UORC_FULL8 - field;
    endfunction

    function automatic logic [7:0] count_step(input logic [7:0] count);
        count_step = count + `UORC_ONE8;
    endfunction

    function automatic logic addr_is_remap(input logic [7:0] addr);
        addr_is_remap = (addr == `UORC_OFS_REMAP);
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    uorc_user_type user_reg;
    uorc_remap_type remap_reg;
    uorc_por_state_type por_state_reg;
    logic [7:0] por_cnt_reg;
    logic [7:0] filt_cnt_reg;
    logic trip_reg;
    logic core_rst_n_reg;
    logic sys_rst_reg;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic [7:0] por_span;
    logic [7:0] filt_span;
    logic detect_on;
    logic wr_fire;
    logic [31:0] remap_next;
    logic [31:0] status_word;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic lowvolt_reset_on;
    logic filter_on;

    assign por_span = span_from_field(user_reg.por_delay);
    assign filt_span = span_from_field(user_reg.lowvolt_filter_count);
    assign detect_on = ~user_reg.lowvolt_detect_disable;
    assign lowvolt_reset_on = ~user_reg.lowvolt_reset_disable;
    assign filter_on = ~user_reg.lowvolt_filter_disable;

    // ----------------------------------------
    // Option word capture
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            user_reg <= `UORC_USER_RST;
        end else if (OPTION_LOAD) begin
            user_reg <= OPTION_WORD;
        end
    end

    // ----------------------------------------
    // Core release delay
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            por_state_reg <= UORC_POR_WAIT;
            por_cnt_reg <= 8'h00;
            core_rst_n_reg <= 1'b0;
        end else begin
            case (por_state_reg)
                UORC_POR_WAIT: begin
                    // Delay starts on the first load after reset
                    por_cnt_reg <= 8'h00;
                    if (OPTION_LOAD) begin
                        por_state_reg <= UORC_POR_DELAY;
                    end
                end
                UORC_POR_DELAY: begin
                    if (por_cnt_reg >= por_span) begin
                        por_state_reg <= UORC_POR_RUN;
                        core_rst_n_reg <= 1'b1;
                    end else if (SLOW_OSC_TICK) begin
                        por_cnt_reg <= count_step(por_cnt_reg);
                    end
                end
                UORC_POR_RUN: begin
                    // Later loads never restart the delay
                    core_rst_n_reg <= 1'b1;
                end
                default: begin
                    por_state_reg <= UORC_POR_WAIT;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Low supply filter
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            filt_cnt_reg <= 8'h00;
            trip_reg <= 1'b0;
        end else if (!detect_on || !SUPPLY_BELOW_TRIP) begin
            filt_cnt_reg <= 8'h00;
            trip_reg <= 1'b0;
        end else if (!filter_on) begin
            filt_cnt_reg <= 8'h00;
            trip_reg <= 1'b1;
        end else if (filt_cnt_reg >= filt_span) begin
            trip_reg <= 1'b1;
        end else if (SLOW_OSC_TICK) begin
            filt_cnt_reg <= count_step(filt_cnt_reg);
        end
    end

    // ----------------------------------------
    // System reset request
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            sys_rst_reg <= 1'b0;
        end else begin
            sys_rst_reg <= trip_reg & lowvolt_reset_on;
        end
    end

    // ----------------------------------------
    // Remap register
    // ----------------------------------------
    always_comb begin
        remap_next = remap_reg;
        for (int i = 0; i < 4; i++) begin
            if (w_strb_reg[i]) begin
                remap_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            remap_reg <= `UORC_REMAP_RST;
        end else if (wr_fire && addr_is_remap(aw_addr_reg)) begin
            remap_reg <= remap_next;
        end
    end

    // ----------------------------------------
    // Handshake strobes
    // ----------------------------------------
    assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID & S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            w_held_reg <= 1'b0;
            w_data_reg <= `UORC_ZERO32;
            w_strb_reg <= 4'h0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `UORC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            if (addr_is_remap(aw_addr_reg)) begin
                bresp_reg <= `UORC_RESP_OKAY;
            end else begin
                bresp_reg <= `UORC_RESP_SLVERR;
            end
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign status_word = {28'h0000000, SUPPLY_BELOW_TRIP, trip_reg,
        sys_rst_reg, core_rst_n_reg};

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= `UORC_ZERO32;
            rresp_reg <= `UORC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `UORC_RESP_OKAY;
            if (S_AXI_ARADDR == `UORC_OFS_USER) begin
                rdata_reg <= user_reg;
            end else if (S_AXI_ARADDR == `UORC_OFS_REMAP) begin
                rdata_reg <= remap_reg;
            end else if (S_AXI_ARADDR == `UORC_OFS_STATUS) begin
                rdata_reg <= status_word;
            end else begin
                rdata_reg <= `UORC_ZERO32;
                rresp_reg <= `UORC_RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
    assign S_AXI_WREADY = ~w_held_reg & ~bvalid_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    assign CORE_RESET_N = core_rst_n_reg;
    assign SYSTEM_RESET_REQ = sys_rst_reg;
    assign LOW_SUPPLY_TRIP = trip_reg;
    assign LOWVOLT_DETECT_ON = detect_on;
    assign LOWVOLT_LEVEL_CODE = `UORC_FULL4 - user_reg.lowvolt_level_select;
    assign VECTOR_REMAP_ENABLE = remap_reg.vector_remap_enable;
    assign VECTOR_TABLE_BASE = remap_reg.vector_table_base;

endmodule
